/* verilog/sahi_pkg.sv */
// =====================================================================
// shared constants of the serial converter host interface
// =====================================================================
package sahi_pkg;

    // widths of the serial words and of the edge counters
    localparam int ADDR_BITS = 4;
    localparam int RES_BITS = 10;
    localparam int EDGE_CNT_BITS = 4;

    // serial clock edge counts, counted from the start of a frame
    localparam logic [3:0] ADDR_CAPTURE_EDGES = 4'h4;
    localparam logic [3:0] SAMPLE_START_FALL = 4'h4;
    localparam logic [3:0] CONV_START_FALL = 4'hA;
    localparam logic [3:0] EDGE_CNT_MAX = 4'hF;

    // input selector: 11 external inputs, then three self-test voltages
    localparam logic [3:0] EXT_INPUTS = 4'hB;
    localparam logic [3:0] SOURCES = 4'hE;
    localparam logic [3:0] UNMAPPED_SRC = 4'hB;

    // values after reset, and the first trial word of a conversion
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [3:0] ADDR_RESET = 4'h0;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic EOC_RESET = 1'b1;
    localparam logic [9:0] TRIAL_MSB = 10'h200;

    // timing of one approximation step
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAR_STEP_NS = 100;
    localparam int SAR_STEP_CYCLES = (SAR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // result buffer
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        SAR_IDLE,
        SAR_CONV,
        SAR_STORE
    } sahi_sar_state_t;

endpackage

/* verilog/sahi_fifo.sv */
`timescale 1ns/1ns
// =====================================================================
// small valid/ready buffer, flip-flop storage addressed by index
// =====================================================================
module sahi_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [IW-1:0] wr_idx;
        logic [IW-1:0] rd_idx;
        logic [CW-1:0] count;
    } sahi_fifo_st_t;

    sahi_fifo_st_t r_reg;
    sahi_fifo_st_t r_next;
    logic push;
    logic pop;

    function automatic logic [IW-1:0] wrap_inc(input logic [IW-1:0] idx);
        wrap_inc = (idx == IW'(DEPTH - 1)) ? '0 : IW'(idx + 1'b1);
    endfunction

    assign in_ready_out = (r_reg.count != CW'(DEPTH));
    assign out_valid_out = (r_reg.count != '0);
    assign out_data_out = r_reg.mem[r_reg.rd_idx];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_reg.wr_idx] = in_data_in;
            r_next.wr_idx = wrap_inc(r_reg.wr_idx);
        end
        if (pop) begin
            r_next.rd_idx = wrap_inc(r_reg.rd_idx);
        end
        if (push && !pop) begin
            r_next.count = CW'(r_reg.count + 1'b1);
        end else if (pop && !push) begin
            r_next.count = CW'(r_reg.count - 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg <= '0;
        end else if (ce_in) begin
            r_reg <= r_next;
        end
    end

endmodule

/* verilog/sahi_top.sv */
`timescale 1ns/1ns
// What this block does
// - host sends 4 address bits msb first, taken on first four clock rises
// - after four address bits the address pin is ignored until frame ends
// - captured address selects the next conversion, not the one being read
// - chip select falling clears counters and enables pins within three clocks
// - chip select rising stops address and serial clock within two clocks
// - serial data pin floats while chip select high, driven while low
// - frame start drives msb of previous result on the data pin
// - each serial clock fall shifts next bit; lsb on ninth fall
// - from tenth fall on, data pin held low
// - conversion done rises when a new result is available
// - selector offers 14 sources: 11 external, three self-test
// - ten-bit successive approximation, sampling started and ended by serial clock falls
// - conversion done falls on tenth fall, low until result is ready
// - sampling from fourth to tenth fall, then state machine converts
module sahi_top
    import sahi_pkg::*;
#(
    parameter int SAR_STEP_CYCLES = sahi_pkg::SAR_STEP_CYCLES
) (
    // clock, reset, enable
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic CE_IN,
    // host serial port pins
    input wire logic CS_B_IN,
    input wire logic IO_CLK_IN,
    input wire logic ADDR_IN,
    output logic DATA_OUT,
    output logic DATA_OE_OUT,
    output logic EOC_OUT,
    // converter core
    input wire logic CMP_IN,
    output logic SAMPLE_OUT,
    output logic [sahi_pkg::ADDR_BITS-1:0] SRC_SEL_OUT,
    output logic [sahi_pkg::RES_BITS-1:0] TRIAL_OUT
);
    import sahi_pkg::*;

    // =================================================================
    // state
    // =================================================================
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic clk_s1;
        logic clk_s2;
        logic clk_d;
        logic adr_s1;
        logic adr_s2;
        logic [EDGE_CNT_BITS-1:0] rise_cnt;
        logic [EDGE_CNT_BITS-1:0] fall_cnt;
        logic [ADDR_BITS-1:0] addr_sh;
        logic [RES_BITS-1:0] tx_sh;
        logic [RES_BITS-1:0] prev_res;
        logic dout;
        logic doe;
        logic eoc;
        logic sample;
        logic [ADDR_BITS-1:0] sel;
        sahi_sar_state_t sar_state;
        logic [RES_BITS-1:0] trial;
        logic [3:0] sar_bit;
        logic [7:0] step_cnt;
    } sahi_state_t;

    localparam sahi_state_t STATE_RESET = '{
        cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
        clk_s1: 1'b0, clk_s2: 1'b0, clk_d: 1'b0,
        adr_s1: 1'b0, adr_s2: 1'b0,
        rise_cnt: '0, fall_cnt: '0,
        addr_sh: ADDR_RESET,
        tx_sh: RESULT_RESET, prev_res: RESULT_RESET,
        dout: 1'b0, doe: 1'b0, eoc: EOC_RESET, sample: 1'b0,
        sel: SEL_RESET, sar_state: SAR_IDLE,
        trial: RESULT_RESET, sar_bit: '0, step_cnt: '0
    };

    sahi_state_t r_reg;
    sahi_state_t r_next;
    logic rst_s1_reg;
    logic rst_n;
    logic cs_act;
    logic cs_start;
    logic cs_end;
    logic rise_ev;
    logic fall_ev;
    logic start_conv;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [RES_BITS-1:0] buf_out_data;
    logic buf_push;

    // unmapped codes fall back to one self-test source
    function automatic logic [ADDR_BITS-1:0] map_src(input logic [ADDR_BITS-1:0] code);
        map_src = (code < SOURCES) ? code : UNMAPPED_SRC;
    endfunction

    // =================================================================
    // reset release
    // =================================================================
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // =================================================================
    // events seen through the synchronisers
    // =================================================================
    assign cs_act = !r_reg.cs_s2;
    assign cs_start = CE_IN && r_reg.cs_d && !r_reg.cs_s2;
    assign cs_end = CE_IN && !r_reg.cs_d && r_reg.cs_s2;
    // edges only count inside a frame; outside it the clock pin is disabled
    assign rise_ev = CE_IN && cs_act && !cs_start && r_reg.clk_s2 && !r_reg.clk_d;
    assign fall_ev = CE_IN && cs_act && !cs_start && !r_reg.clk_s2 && r_reg.clk_d;
    assign start_conv = fall_ev && (r_reg.fall_cnt == CONV_START_FALL - 4'h1)
        && (r_reg.sar_state == SAR_IDLE);
    assign buf_push = (r_reg.sar_state == SAR_STORE) && buf_in_ready;

    // =================================================================
    // result buffer between converter and shifter
    // =================================================================
    // a result waits here until the next frame starts; when both entries are
    // full the converter holds in its store state, so no result is dropped
    sahi_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .in_valid_in(r_reg.sar_state == SAR_STORE),
        .in_ready_out(buf_in_ready),
        .in_data_in(r_reg.trial),
        .out_valid_out(buf_out_valid),
        .out_ready_in(cs_start),
        .out_data_out(buf_out_data)
    );

    // =================================================================
    // next state
    // =================================================================
    always_comb begin
        logic [RES_BITS-1:0] t;
        logic [RES_BITS-1:0] load;
        t = r_reg.trial;
        load = buf_out_valid ? buf_out_data : r_reg.prev_res;
        r_next = r_reg;
        r_next.cs_s1 = CS_B_IN;
        r_next.cs_s2 = r_reg.cs_s1;
        r_next.cs_d = r_reg.cs_s2;
        r_next.clk_s1 = IO_CLK_IN;
        r_next.clk_s2 = r_reg.clk_s1;
        r_next.clk_d = r_reg.clk_s2;
        r_next.adr_s1 = ADDR_IN;
        r_next.adr_s2 = r_reg.adr_s1;

        // serial side
        if (cs_start) begin
            r_next.rise_cnt = '0;
            r_next.fall_cnt = '0;
            r_next.sample = 1'b0;
            r_next.prev_res = load;
            r_next.tx_sh = load;
            r_next.dout = load[RES_BITS-1];
            r_next.doe = 1'b1;
        end else if (!cs_act) begin
            r_next.doe = 1'b0;
            r_next.dout = 1'b0;
            r_next.sample = 1'b0;
        end else begin
            if (rise_ev && (r_reg.rise_cnt < ADDR_CAPTURE_EDGES)) begin
                r_next.addr_sh = {r_reg.addr_sh[ADDR_BITS-2:0], r_reg.adr_s2};
                r_next.rise_cnt = r_reg.rise_cnt + 4'h1;
            end
            if (fall_ev) begin
                if (r_reg.fall_cnt != EDGE_CNT_MAX) begin
                    r_next.fall_cnt = r_reg.fall_cnt + 4'h1;
                end
                if (r_reg.fall_cnt < CONV_START_FALL - 4'h1) begin
                    r_next.tx_sh = {r_reg.tx_sh[RES_BITS-2:0], 1'b0};
                    r_next.dout = r_reg.tx_sh[RES_BITS-2];
                end else begin
                    r_next.dout = 1'b0;
                end
                if (r_reg.fall_cnt == SAMPLE_START_FALL - 4'h1) begin
                    r_next.sample = 1'b1;
                    r_next.sel = map_src(r_reg.addr_sh);
                end
                if (r_reg.fall_cnt == CONV_START_FALL - 4'h1) begin
                    r_next.sample = 1'b0;
                    r_next.eoc = 1'b0;
                end
            end
        end

        // converter side, keeps running across chip select changes
        case (r_reg.sar_state)
            SAR_IDLE: begin
                if (start_conv) begin
                    r_next.sar_state = SAR_CONV;
                    r_next.trial = TRIAL_MSB;
                    r_next.sar_bit = 4'(RES_BITS - 1);
                    r_next.step_cnt = '0;
                end
            end
            SAR_CONV: begin
                if (r_reg.step_cnt == 8'(SAR_STEP_CYCLES - 1)) begin
                    r_next.step_cnt = '0;
                    if (!CMP_IN) begin
                        t[r_reg.sar_bit] = 1'b0;
                    end
                    if (r_reg.sar_bit == 4'h0) begin
                        r_next.sar_state = SAR_STORE;
                    end else begin
                        t[r_reg.sar_bit - 4'h1] = 1'b1;
                        r_next.sar_bit = r_reg.sar_bit - 4'h1;
                    end
                    r_next.trial = t;
                end else begin
                    r_next.step_cnt = r_reg.step_cnt + 8'h01;
                end
            end
            SAR_STORE: begin
                if (buf_in_ready) begin
                    r_next.sar_state = SAR_IDLE;
                    r_next.eoc = 1'b1;
                end
            end
            default: begin
                r_next.sar_state = SAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= STATE_RESET;
        end else if (CE_IN) begin
            r_reg <= r_next;
        end
    end

    // =================================================================
    // outputs
    // =================================================================
    assign DATA_OUT = r_reg.dout;
    assign DATA_OE_OUT = r_reg.doe;
    assign EOC_OUT = r_reg.eoc;
    assign SAMPLE_OUT = r_reg.sample;
    assign SRC_SEL_OUT = r_reg.sel;
    assign TRIAL_OUT = r_reg.trial;

    // =================================================================
    // checks
    // =================================================================
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!rst_n);

    sequence seq_conv_start;
        start_conv;
    endsequence

    sequence seq_converting;
        (r_reg.sar_state == SAR_CONV)[*8];
    endsequence

    chk_addr_capture: assert property (
        rise_ev && (r_reg.rise_cnt < ADDR_CAPTURE_EDGES)
        |=> r_reg.addr_sh == {$past(r_reg.addr_sh[ADDR_BITS-2:0]), $past(r_reg.adr_s2)})
        else $error("address bit not shifted in on serial clock rise");

    chk_addr_ignored: assert property (
        (r_reg.rise_cnt == ADDR_CAPTURE_EDGES) && !cs_start
        |=> $stable(r_reg.addr_sh))
        else $error("address changed after four bits were captured");

    chk_next_source: assert property (
        fall_ev && (r_reg.fall_cnt == SAMPLE_START_FALL - 4'h1)
        |=> SRC_SEL_OUT == map_src($past(r_reg.addr_sh)) && SAMPLE_OUT)
        else $error("selector not taken from captured address at sampling start");

    chk_cs_start: assert property (
        cs_start |=> DATA_OE_OUT && (r_reg.fall_cnt == '0) && (r_reg.rise_cnt == '0))
        else $error("frame start did not clear counters and enable output");

    chk_cs_release: assert property (
        cs_end |=> !DATA_OE_OUT && !DATA_OUT && !SAMPLE_OUT)
        else $error("output still enabled after chip select went high");

    chk_msb_first: assert property (
        cs_start && buf_out_valid |=> DATA_OUT == $past(buf_out_data[RES_BITS-1]))
        else $error("msb of previous result not presented at frame start");

    chk_bit_shift: assert property (
        fall_ev && (r_reg.fall_cnt < CONV_START_FALL - 4'h1)
        |=> DATA_OUT == $past(r_reg.tx_sh[RES_BITS-2]))
        else $error("data pin did not advance to next lower bit");

    chk_zero_tail: assert property (
        fall_ev && (r_reg.fall_cnt >= CONV_START_FALL - 4'h1) |=> !DATA_OUT)
        else $error("data pin not low after the tenth serial clock fall");

    chk_eoc_fall: assert property (
        fall_ev && (r_reg.fall_cnt == CONV_START_FALL - 4'h1) |=> !EOC_OUT && !SAMPLE_OUT)
        else $error("conversion done not low after tenth fall");

    chk_eoc_rise: assert property (
        buf_push |=> EOC_OUT && buf_out_valid)
        else $error("conversion done not raised when result was stored");

    chk_conv_run: assert property (
        seq_conv_start |=> seq_converting)
        else $error("successive approximation did not run after start");

endmodule

/* verification/sahi_host_model.sv */
`timescale 1ns/1ns
// =====================================================================
// host serial port: chip select, serial clock, address, result capture
// =====================================================================
module sahi_host_model (
    // system clock, paces the pins and samples the last driven data bit
    input wire logic clk_in,
    // pins toward the converter
    output logic cs_b_out,
    output logic io_clk_out,
    output logic addr_out,
    input wire logic data_in,
    input wire logic data_oe_in,
    input wire logic eoc_in,
    input wire logic sample_in
);
    logic last_bit;
    logic wire_bit;

    // no pull on the data line: a floating pin shows the inverse of its last value
    assign wire_bit = data_oe_in ? data_in : ~last_bit;

    always @(posedge clk_in) begin
        if (data_oe_in === 1'b1) begin
            last_bit <= data_in;
        end
    end

    initial begin
        cs_b_out = 1'b1;
        io_clk_out = 1'b0;
        addr_out = 1'b0;
        last_bit = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // serial clock period is 16 system clocks, high and low 8 each
    task automatic frame(input logic [3:0] addr, input int nclk,
                         output logic [15:0] bits, output logic [3:0] flags);
        bits = 16'h0000;
        flags = 4'h0;
        cs_b_out = 1'b0;
        wait_n(8);
        flags[3] = data_oe_in;
        for (int i = 0; i < nclk; i++) begin
            // past the address, drive ones that must be ignored
            addr_out = (i < 4) ? addr[3 - (i % 4)] : 1'b1;
            wait_n(4);
            bits = {bits[14:0], wire_bit};
            io_clk_out = 1'b1;
            wait_n(8);
            if (i == 3) flags[2] = sample_in;
            if (i == 6) flags[1] = sample_in;
            io_clk_out = 1'b0;
            wait_n(4);
            if (i == 9) flags[0] = ~eoc_in;
        end
        wait_n(4);
        cs_b_out = 1'b1;
        wait_n(8);
    endtask

    // serial clocks with chip select high, which must be ignored
    task automatic idle_clocks(input int n);
        repeat (n) begin
            io_clk_out = 1'b1;
            wait_n(8);
            io_clk_out = 1'b0;
            wait_n(8);
        end
    endtask
endmodule

/* verification/sahi_top_test.sv */
`timescale 1ns/1ns
// =====================================================================
// self-checking bench of the serial converter host interface
// =====================================================================
module sahi_top_test;
    import sahi_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, io_clk, addr, data, data_oe, eoc, sample;
    logic cmp = 1'b0;
    logic [3:0] src_sel;
    logic [9:0] trial;
    logic [9:0] vin = 10'h000;
    logic [9:0] prev;
    logic [15:0] bits;
    logic [3:0] flags;
    int err_count = 0;
    int comparisons = 0;

    always #5 sys_clk = ~sys_clk;
    // stand-in for the analog comparator: keep the trial bit while vin is not below it
    always @(negedge sys_clk) cmp <= (vin >= trial);

    sahi_top #(.SAR_STEP_CYCLES(1)) u_sahi_top (
        .SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b), .CE_IN(1'b1),
        .CS_B_IN(cs_b), .IO_CLK_IN(io_clk), .ADDR_IN(addr),
        .DATA_OUT(data), .DATA_OE_OUT(data_oe), .EOC_OUT(eoc),
        .CMP_IN(cmp), .SAMPLE_OUT(sample), .SRC_SEL_OUT(src_sel), .TRIAL_OUT(trial)
    );

    sahi_host_model u_sahi_host_model (
        .clk_in(sys_clk), .cs_b_out(cs_b), .io_clk_out(io_clk), .addr_out(addr),
        .data_in(data), .data_oe_in(data_oe), .eoc_in(eoc), .sample_in(sample)
    );

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_eoc();
        int n;
        n = 0;
        while (eoc !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, eoc, 1'b1);
            summarize();
        end
    endtask

    // one full frame, then the converter is let finish
    task automatic do_frame(input logic [3:0] a, input int n);
        logic [3:0] sel;
        logic [15:0] exp;
        sel = (a < SOURCES) ? a : UNMAPPED_SRC;
        exp = {prev, 6'h00} >> (16 - n);
        u_sahi_host_model.frame(a, n, bits, flags);
        chk_bit(flags[3], 1'b1);
        chk_word(bits, exp);
        chk_bit(flags[2], 1'b0);
        chk_bit(flags[1], 1'b1);
        chk_bit(flags[0], 1'b1);
        chk_word({12'h000, src_sel}, {12'h000, sel});
        chk_bit(data_oe, 1'b0);
        chk_bit(data, 1'b0);
        wait_eoc();
        chk_word({6'h00, trial}, {6'h00, vin});
        prev = vin;
    endtask

    task automatic test_reset();
        chk_bit(eoc, EOC_RESET);
        chk_bit(data_oe, 1'b0);
        chk_bit(sample, 1'b0);
        chk_word({12'h000, src_sel}, {12'h000, SEL_RESET});
        chk_word({6'h00, trial}, {6'h00, RESULT_RESET});
        $display("test_reset done");
    endtask

    // every address code, frame lengths from 10 to 16 clocks
    task automatic test_all_codes();
        for (int a = 0; a < 16; a++) begin
            vin = (a == 15) ? 10'h3FF : 10'(a * 68);
            do_frame(4'(a), 10 + (a % 7));
        end
        $display("test_all_codes done");
    endtask

    // a frame cut short, then serial clocks with chip select high
    task automatic test_abort();
        vin = 10'h155;
        u_sahi_host_model.frame(4'h2, 6, bits, flags);
        chk_word(bits, {10'h000, prev[9:4]});
        chk_bit(sample, 1'b0);
        chk_bit(eoc, 1'b1);
        u_sahi_host_model.idle_clocks(12);
        chk_bit(sample, 1'b0);
        chk_bit(eoc, 1'b1);
        chk_bit(data_oe, 1'b0);
        // counters must restart, so the tenth fall of this frame starts a conversion
        do_frame(4'h3, 10);
        $display("test_abort done");
    endtask

    initial begin
        prev = RESULT_RESET;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge sys_clk);
        test_reset();
        test_all_codes();
        test_abort();
        summarize();
    end
endmodule
